// file: hdl/adc_host_consts.svh
// Timing counts and field positions for the converter host controller.
// Assumes a 100 MHz ref_clk; included by the controller module only.
`ifndef ADC_HOST_CONSTS_SVH
`define ADC_HOST_CONSTS_SVH

`define CLK_PERIOD_NS      10
`define CONV_MAX_NS        530
`define CONV_MAX_CYC       ((`CONV_MAX_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_MIN_NS      50
`define STROBE_CYC         ((`STROBE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define START_LOW_NS       20
`define START_LOW_CYC      ((`START_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CHAN_LSB           0
`define DEV_ADDR_LSB       3

`endif

// file: hdl/adc_host_ctrl.sv
// Host controller for an 8-bit sampling converter on a parallel pin port.
// Assumes the converter pins connect directly; data pins are inputs here.
//
// How it works
// - Channel pins come from address bits.
// - Select decodes only upper address bits.
// - Standalone: read and select follow done.
// - Start alone converts, outputs, sets mode.
// - Address held stable during access.
`timescale 1ns/1ns
`include "adc_host_consts.svh"
module adc_host_ctrl
    import adc_host_pkg::*;
#(
    parameter int          CHAN_BITS  = 3,
    parameter int          ADDR_BITS  = 16,
    parameter logic [12:0] DEV_BASE   = 13'h0001
) (
    input  wire logic                 ref_clk,        // 100 MHz clock
    input  wire logic                 resetn,         // Sync reset, low active
    input  wire logic                 req_valid,      // Request a conversion
    input  wire logic [ADDR_BITS-1:0] req_addr,       // Address of the access
    input  wire logic                 req_sleep,      // Power down after it
    input  wire logic                 standalone,     // Single-channel tied mode
    output logic                      req_ready,      // Idle, may take request
    output logic                      res_valid,      // Result pulse
    output logic [7:0]                res_data,       // Captured result
    output logic [CHAN_BITS-1:0]      res_chan,       // Channel of result
    output logic                      convert_start_n,// Start pin
    output logic                      rd_n,           // Read strobe pin
    output logic                      cs_n,           // Chip select pin
    output logic [CHAN_BITS-1:0]      chan_addr,      // Channel address pins
    input  wire logic                 done_n,         // Conversion-done pin
    input  wire logic [7:0]           data_pins       // Result data pins
);
    // Refuse shapes that the channel slice and the select decode cannot serve
    if (CHAN_BITS < 1 || CHAN_BITS > 3 || ADDR_BITS != 16) begin
        $error("adc_host_ctrl: unsupported parameters");
    end

    localparam logic [9:0] CONV_CYC   = 10'(`CONV_MAX_CYC);
    localparam logic [9:0] STROBE_CYC = 10'(`STROBE_CYC);
    localparam logic [9:0] START_CYC  = 10'(`START_LOW_CYC);

    // Select decode looks only at bits above the channel field
    function automatic logic dev_hit(input logic [ADDR_BITS-1:0] a);
        dev_hit = (a[ADDR_BITS-1:`DEV_ADDR_LSB] == DEV_BASE);
    endfunction

    logic done_s;                     // Synchronised done level
    logic done_prev_q, done_prev_d;   // Last done level
    logic [7:0] data_s;               // Synchronised data pins
    host_state_t st_q, st_d;          // Controller state
    logic [9:0]  cnt_q, cnt_d;        // Cycle counter
    logic        sleep_q, sleep_d;    // Power down requested
    logic [ADDR_BITS-1:0] addr_q, addr_d; // Held access address
    logic        convs_q, convs_d;    // Start pin level
    logic        rd_q, rd_d;          // Read strobe level
    logic        cs_q, cs_d;          // Select level
    logic [CHAN_BITS-1:0] chan_q, chan_d; // Channel pins
    logic        rv_q, rv_d;          // Result pulse
    logic [7:0]  rdat_q, rdat_d;      // Result byte
    logic [CHAN_BITS-1:0] rch_q, rch_d; // Result channel
    logic        rdy_q, rdy_d;        // Ready for a request
    logic [7:0]  hold_q, hold_d;      // Data last seen while done was low
    logic        done_rise;           // Synchronised done rising edge

    pin_sync #(.WIDTH(9)) u_sync (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .pin_raw ({done_n, data_pins}),
        .level_q ({done_s, data_s})
    );

    assign done_rise = done_s && !done_prev_q;

    // Sequencer next state
    always_comb begin
        st_d        = st_q;
        cnt_d       = cnt_q;
        sleep_d     = sleep_q;
        addr_d      = addr_q;
        convs_d     = convs_q;
        rd_d        = rd_q;
        cs_d        = cs_q;
        chan_d      = chan_q;
        rv_d        = 1'b0;
        rdat_d      = rdat_q;
        rch_d       = rch_q;
        rdy_d       = 1'b0;
        done_prev_d = done_s;
        // Tied mode: the pins flip to the released level in the same cycle
        // that the synchronised done rises, so keep the copy from before
        hold_d      = done_s ? hold_q : data_s;
        case (st_q)
            ST_IDLE: begin
                rdy_d = 1'b1;
                if (req_valid && rdy_q && (standalone || dev_hit(req_addr))) begin
                    addr_d  = req_addr;
                    sleep_d = req_sleep;
                    convs_d = 1'b0;
                    cnt_d   = 10'h000;
                    rdy_d   = 1'b0;
                    st_d    = ST_START;
                end
            end
            ST_START: begin
                cnt_d = cnt_q + 10'h001;
                if (cnt_q + 10'h001 >= START_CYC && !sleep_q) begin
                    convs_d = 1'b1;               // Release early: stays powered
                end
                if (cnt_q + 10'h001 >= START_CYC) begin
                    cnt_d = 10'h000;
                    st_d  = ST_WAIT;
                end
            end
            ST_WAIT: begin
                cnt_d = cnt_q + 10'h001;
                if (standalone && done_rise) begin
                    rdat_d = hold_q;
                    rch_d  = '0;
                    rv_d   = 1'b1;
                    st_d   = ST_DONE;
                end else if (!standalone && !done_s) begin
                    chan_d = CHAN_BITS'(addr_q[`CHAN_LSB +: 3]);
                    cs_d   = 1'b0;                // Done taken as the go
                    cnt_d  = 10'h000;
                    st_d   = ST_READ;
                end else if (cnt_q >= CONV_CYC + STROBE_CYC) begin
                    st_d = ST_DONE;               // Missing done: give up
                end
            end
            ST_READ: begin
                cnt_d = cnt_q + 10'h001;
                rd_d  = 1'b0;                     // Channel latched here
                if (cnt_q >= STROBE_CYC + 10'h004) begin
                    rdat_d = data_s;              // Sampled while low
                    rch_d  = chan_q;
                    rv_d   = 1'b1;
                    rd_d   = 1'b1;                // Rise ends done early
                    cs_d   = 1'b1;
                    st_d   = ST_DONE;
                end
            end
            ST_DONE: begin
                convs_d = 1'b1;                   // Rising edge powers up
                st_d    = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            st_q <= ST_IDLE;
            cnt_q <= 10'h000;
            sleep_q <= 1'b0;
            addr_q <= '0;
            convs_q <= 1'b1;
            rd_q <= 1'b1;
            cs_q <= 1'b1;
            chan_q <= '0;
            rv_q <= 1'b0;
            rdat_q <= 8'h00;
            hold_q <= 8'h00;
            rch_q <= '0;
            rdy_q <= 1'b0;
            done_prev_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sleep_q <= sleep_d;
            addr_q <= addr_d;
            convs_q <= convs_d;
            rd_q <= rd_d;
            cs_q <= cs_d;
            chan_q <= chan_d;
            rv_q <= rv_d;
            rdat_q <= rdat_d;
            hold_q <= hold_d;
            rch_q <= rch_d;
            rdy_q <= rdy_d;
            done_prev_q <= done_prev_d;
        end
    end

    assign req_ready       = rdy_q;
    assign res_valid       = rv_q;
    assign res_data        = rdat_q;
    assign res_chan        = rch_q;
    assign convert_start_n = convs_q;
    assign rd_n            = rd_q;
    assign cs_n            = cs_q;
    assign chan_addr       = chan_q;

    // Read strobe only ever falls with select already low
    chk_rd_under_cs: assert property (@(posedge ref_clk) disable iff (!resetn)
        !rd_q |-> !cs_q) else $error("read low without select");

    // Start falls one cycle after accepted request
    chk_start_fall: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_q == ST_IDLE && st_d == ST_START) |=> !convs_q) else $error("start not driven low");

    // Sleep request keeps start low through the wait state
    chk_sleep_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_q == ST_WAIT && sleep_q) |-> !convs_q) else $error("start released in sleep");

    // Channel pins stable across a read strobe
    chk_chan_stable: assert property (@(posedge ref_clk) disable iff (!resetn)
        (!rd_q && !$past(rd_q)) |-> $stable(chan_q)) else $error("channel moved in read");

    // Read strobe ends within bounded cycles
    chk_read_bound: assert property (@(posedge ref_clk) disable iff (!resetn)
        $fell(rd_q) |-> ##[1:12] rd_q) else $error("read strobe too long");

    // A result pulse lasts one cycle
    chk_res_pulse: assert property (@(posedge ref_clk) disable iff (!resetn)
        rv_q |=> !rv_q) else $error("result pulse too long");

    // Standalone mode never drives select or read, nor enters the read phase
    chk_standalone_pins: assert property (@(posedge ref_clk) disable iff (!resetn)
        (standalone && st_q == ST_WAIT) |=> (rd_q && cs_q && st_q != ST_READ))
        else $error("standalone drove strobes");

    // Off-device address never starts an access outside standalone mode
    chk_decode: assert property (@(posedge ref_clk) disable iff (!resetn)
        (st_q == ST_IDLE && req_valid && !standalone && !dev_hit(req_addr)) |=> st_q == ST_IDLE)
        else $error("decode miss accepted");

    // Tied mode: done rising while waiting is the end of the data window
    sequence s_tied_rise;
        standalone && st_q == ST_WAIT && done_rise;
    endsequence

    // The byte handed over is the one held while done was low
    chk_tied_capture: assert property (@(posedge ref_clk) disable iff (!resetn)
        s_tied_rise |=> (rv_q && rdat_q == $past(hold_q))) else $error("tied capture missed");
endmodule

// file: hdl/adc_host_pkg.sv
// Types shared by the converter host controller.
// Assumes the constants header sits beside it.
package adc_host_pkg;
    // Pins driven toward the converter
    typedef struct packed {
        logic       convert_start_n;  // Conversion start, low starts
        logic       rd_n;             // Read strobe
        logic       cs_n;             // Chip select
        logic [2:0] chan;             // Channel address pins
    } conv_pins_t;

    // Controller states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_START = 3'b001,
        ST_WAIT  = 3'b010,
        ST_READ  = 3'b011,
        ST_DONE  = 3'b100
    } host_state_t;
endpackage

// file: hdl/pin_sync.sv
// Three-stage synchroniser for a pin from outside ref_clk.
// Assumes the pin may change at any time relative to the clock.
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,  // System clock
    input  wire logic             resetn,   // Sync reset, low active
    input  wire logic [WIDTH-1:0] pin_raw,  // Raw pin
    output logic      [WIDTH-1:0] level_q   // Filtered level
);
    logic [WIDTH-1:0] s1_q, s2_q, s3_q;   // Stages
    logic [WIDTH-1:0] level_d;            // Next filtered value

    // A zero-width bundle has nothing to carry
    if (WIDTH < 1) begin
        $error("pin_sync: unsupported width");
    end

    // Accept a change only when stages two and three agree
    always_comb begin
        level_d = level_q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                level_d[i] = s3_q[i];
            end
        end
    end

    // Registers; idle level is high for these strobes
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s1_q    <= '1;
            s2_q    <= '1;
            s3_q    <= '1;
            level_q <= '1;
        end else begin
            s1_q    <= pin_raw;
            s2_q    <= s1_q;
            s3_q    <= s2_q;
            level_q <= level_d;
        end
    end
endmodule

// file: verif/adc_dev_model.sv
// Behavioural model of the 8-bit converter seen from its parallel pins.
// Assumes pins come straight from the host controller or the bench's tie-offs.
`timescale 1ns/1ns
module adc_dev_model #(
    parameter int DONE_NS = 100                // Done pulse width, under the 110 ns ceiling
) (
    input  wire logic       convert_start_n,   // Start pin, low starts
    input  wire logic       rd_n,              // Read strobe
    input  wire logic       cs_n,              // Chip select
    input  wire logic [2:0] chan_addr,         // Channel address pins
    input  wire logic [9:0] conv_ns,           // Conversion time in ns
    input  wire logic       mute,              // Never finish a conversion
    output logic            done_n,            // Conversion-done pulse
    output logic      [7:0] data_pins,         // Result pins
    output logic            asleep,            // Powered down
    output logic      [2:0] mux_q              // Latched channel
);
    logic [7:0] out_q;                         // Output register
    logic       rd_up;                         // Read rose during done
    int         t;                             // Done pulse timer

    initial begin
        done_n = 1'b1;
        asleep = 1'b0;
        mux_q  = 3'h0;
        out_q  = 8'h00;
        rd_up  = 1'b0;
    end

    // Channel taken on the read strobe's fall; used by the next conversion
    always @(negedge rd_n) mux_q = chan_addr;

    // Rising read cuts the done pulse short
    always @(posedge rd_n) rd_up = 1'b1;

    // Conversion begins on the start fall; result on a pattern of the channel
    always @(negedge convert_start_n) begin
        if (!mute) begin
            #(conv_ns);
            out_q  = {mux_q, ~mux_q, 2'b10};
            rd_up  = 1'b0;
            done_n = 1'b0;
            for (t = 0; t < DONE_NS && !rd_up; t++) #1;
            done_n = 1'b1;
            if (!convert_start_n) asleep = 1'b1;
        end
    end

    // Start rising powers the part back up
    always @(posedge convert_start_n) asleep = 1'b0;

    // Not selected: no bus keeper, so show the inverse rather than stale data
    assign data_pins = (!cs_n && !rd_n) ? out_q : ~out_q;
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the converter host controller.
// Assumes the device model file is compiled first.
`timescale 1ns/1ns
module tb_top;
    import adc_host_pkg::*;
    logic        ref_clk = 1'b0;     // 100 MHz clock
    logic        resetn = 1'b0;      // Sync reset
    logic        req_valid = 1'b0;   // Request strobe
    logic [15:0] req_addr = 16'h0000;// Request address
    logic        req_sleep = 1'b0;   // Power down request
    logic        standalone = 1'b0;  // Tied mode
    logic        req_ready, res_valid, convert_start_n, rd_n, cs_n, done_n, asleep, mute = 1'b0;
    logic [7:0]  res_data, data_pins;
    logic [2:0]  res_chan, chan_addr, mux_q;
    logic [9:0]  conv_ns = 10'h12c;  // 300 ns
    logic        saw_sleep, saw_start;
    int          error_cnt = 0, checks = 0, cyc = 0, prev = 0;
    wire         dev_rd = standalone ? done_n : rd_n;
    wire         dev_cs = standalone ? done_n : cs_n;
    wire [2:0]   dev_chan = standalone ? 3'h0 : chan_addr;

    always #5 ref_clk = ~ref_clk;
    always @(posedge asleep) saw_sleep = 1'b1;
    always @(negedge convert_start_n) saw_start = 1'b1;

    adc_host_ctrl i_adc_host_ctrl (.ref_clk(ref_clk), .resetn(resetn), .req_valid(req_valid),
        .req_addr(req_addr), .req_sleep(req_sleep), .standalone(standalone), .req_ready(req_ready),
        .res_valid(res_valid), .res_data(res_data), .res_chan(res_chan),
        .convert_start_n(convert_start_n), .rd_n(rd_n), .cs_n(cs_n), .chan_addr(chan_addr),
        .done_n(done_n), .data_pins(data_pins));
    adc_dev_model i_adc_dev_model (.convert_start_n(convert_start_n), .rd_n(dev_rd), .cs_n(dev_cs),
        .chan_addr(dev_chan), .conv_ns(conv_ns), .mute(mute), .done_n(done_n),
        .data_pins(data_pins), .asleep(asleep), .mux_q(mux_q));

    // Expected result of a conversion on channel c
    function automatic logic [7:0] pat(input int c);
        pat = {c[2:0], ~c[2:0], 2'b10};
    endfunction

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // One request; waits for the result under a bound and judges it
    task automatic run(input logic [15:0] a, input logic sl, input logic want, input logic [7:0] exp);
        int  n;
        logic got;
        saw_sleep = 1'b0;
        saw_start = 1'b0;
        got = 1'b0;
        for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(posedge ref_clk);
        req_valid <= 1'b1;
        req_addr  <= a;
        req_sleep <= sl;
        @(posedge ref_clk);
        req_valid <= 1'b0;
        for (n = 0; n < 120 && !got; n++) begin
            @(posedge ref_clk);
            got = (res_valid === 1'b1);
        end
        check("res_valid", {7'h0, got}, {7'h0, want});
        if (want) check("res_data", res_data, exp);
    endtask

    // Reset: pins idle high, not ready until released
    task automatic t_reset();
        repeat (3) @(posedge ref_clk);
        check("idle pins", {5'h0, convert_start_n, rd_n, cs_n}, 8'h07);
        check("ready in reset", {7'h0, req_ready}, 8'h00);
        resetn <= 1'b1;
    endtask

    // Every channel, fast and slow conversions alternating
    task automatic t_channels();
        for (int ch = 0; ch < 8; ch++) begin
            // Both keep the end of done inside the 530 ns bound after start
            conv_ns <= ch[0] ? 10'h190 : 10'h12c;
            run({13'h0001, ch[2:0]}, 1'b0, 1'b1, pat(prev));
            check("res_chan", {5'h0, res_chan}, ch[7:0]);
            check("latched channel", {5'h0, mux_q}, ch[7:0]);
            check("no power down", {7'h0, saw_sleep}, 8'h00);
            prev = ch;
        end
    endtask

    // Start held low through the end: part sleeps, then wakes on release
    task automatic t_sleep();
        run(16'h000b, 1'b1, 1'b1, pat(prev));
        check("slept", {7'h0, saw_sleep}, 8'h01);
        repeat (3) @(posedge ref_clk);
        check("woken", {7'h0, asleep}, 8'h00);
        prev = 3;
    endtask

    // Upper bits outside the device base: nothing starts
    task automatic t_miss();
        run(16'h0011, 1'b0, 1'b0, 8'h00);
        check("start on miss", {7'h0, saw_start}, 8'h00);
    endtask

    // Device never answers, then a normal read recovers
    task automatic t_silent();
        mute <= 1'b1;
        run(16'h000d, 1'b0, 1'b0, 8'h00);
        mute <= 1'b0;
        run(16'h000d, 1'b0, 1'b1, pat(prev));
        prev = 5;
    endtask

    // Read and select tied to done; start alone drives the whole cycle
    task automatic t_standalone();
        standalone <= 1'b1;
        run(16'hfff8, 1'b0, 1'b1, pat(prev));
        run(16'h0000, 1'b0, 1'b1, pat(0));
        check("res_chan", {5'h0, res_chan}, 8'h00);
        standalone <= 1'b0;
        prev = 0;
    endtask

    // Cut a hang short
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        t_reset();
        t_channels();
        t_sleep();
        t_miss();
        t_silent();
        t_standalone();
        close_out();
    end
endmodule
